/* File: can_status_pkg.sv */
// How it works
// - transmit fifo: user address reads the head, high then low half
// - receive fifo: user address reads the tail
// - event fifo user address reads the event tail
// - transmit queue user address reads the queue head
// - bus-off flag bit 5 set when transmit count passes 255
// - bus-off flag held in configuration mode, one after reset
// - transmit error-passive flag bit 4 when transmit count above 127
// - receive error-passive flag bit 3 when receive count above 127
// - transmit warning bit 2 while transmit count in 96..127
// - receive warning bit 1 while receive count in 96..127
// - any-warning bit 0 is transmit or receive warning
// - counts register: transmit 15:8, receive 7:0, reset zero
package can_status_pkg;

  // bus and address map
  localparam int AXI_ADDR_W = 12;
  localparam int FIFO_COUNT = 7;
  localparam int UA_W = 32;
  localparam logic [11:0] OFS_EVT_UA_HIGH = 12'h000;
  localparam logic [11:0] OFS_EVT_UA_LOW = 12'h004;
  localparam logic [11:0] OFS_TXQ_UA_HIGH = 12'h008;
  localparam logic [11:0] OFS_TXQ_UA_LOW = 12'h00c;
  localparam logic [11:0] OFS_ERR_FLAGS = 12'h010;
  localparam logic [11:0] OFS_ERR_COUNTS = 12'h014;
  localparam logic [11:0] OFS_INT_STATUS = 12'h018;
  localparam logic [11:0] OFS_INT_MASK = 12'h01c;
  localparam logic [11:0] OFS_FIFO_UA_BASE = 12'h040;
  localparam logic [11:0] OFS_FIFO_STRIDE = 12'h008;
  localparam logic [11:0] OFS_HALF_LOW = 12'h004;

  // error state flag positions
  localparam int BIT_BUS_OFF = 5;
  localparam int BIT_TX_PASSIVE = 4;
  localparam int BIT_RX_PASSIVE = 3;
  localparam int BIT_TX_WARN = 2;
  localparam int BIT_RX_WARN = 1;
  localparam int BIT_ANY_WARN = 0;
  localparam int FLAGS_W = 6;
  localparam int TX_CNT_LSB = 8;
  localparam int RX_CNT_LSB = 0;

  // fault confinement figures
  localparam logic [8:0] BUS_OFF_LIMIT = 9'h0ff;
  localparam logic [7:0] PASSIVE_LIMIT = 8'h7f;
  localparam logic [7:0] WARN_ABOVE = 8'h5f;
  localparam logic [7:0] WARN_BELOW = 8'h80;
  localparam logic [8:0] TX_ERR_STEP = 9'h008;
  localparam logic [8:0] RX_ERR_STEP = 9'h001;
  localparam logic [8:0] RX_SEVERE_STEP = 9'h008;
  localparam logic [8:0] RX_PASSIVE_RELOAD = 9'h078;
  localparam logic [7:0] COUNT_SAT = 8'hff;

  // values after reset
  localparam logic [FLAGS_W-1:0] RST_FLAGS = 6'h20;
  localparam logic [8:0] RST_COUNT = 9'h000;
  localparam logic [UA_W-1:0] RST_UA = 32'h0000_0000;

  // interrupt status and mask layout
  localparam int INT_W = 5;
  localparam int INT_BUS_OFF = 0;
  localparam int INT_TX_PASSIVE = 1;
  localparam int INT_RX_PASSIVE = 2;
  localparam int INT_WARN = 3;
  localparam int INT_RECOVERED = 4;
  localparam logic [INT_W-1:0] RST_INT = 5'h00;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

/* File: err_count_engine.sv */
`timescale 1ns/100ps
module err_count_engine (
  // clock and control
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic config_mode_i,
  // protocol engine events, one-cycle pulses
  input wire logic tx_error_i,
  input wire logic tx_success_i,
  input wire logic rx_error_i,
  input wire logic rx_severe_i,
  input wire logic rx_success_i,
  input wire logic recovered_i,
  // counts and bus-off state
  output logic [7:0] tx_count_o,
  output logic [7:0] rx_count_o,
  output logic bus_off_o
);

  logic [8:0] tec_ff, rec_ff, nxt_tec, nxt_rec;
  logic bus_off_ff, nxt_bus_off;

  always_comb begin
    nxt_tec = tec_ff;
    nxt_rec = rec_ff;
    nxt_bus_off = bus_off_ff;
    if (config_mode_i) begin
      nxt_tec = can_status_pkg::RST_COUNT;
      nxt_rec = can_status_pkg::RST_COUNT;
      nxt_bus_off = 1'b1;
    end else if (bus_off_ff) begin
      // only the recovery sequence brings the node back
      if (recovered_i) begin
        nxt_tec = can_status_pkg::RST_COUNT;
        nxt_rec = can_status_pkg::RST_COUNT;
        nxt_bus_off = 1'b0;
      end
    end else begin
      if (tx_error_i) begin
        nxt_tec = tec_ff + can_status_pkg::TX_ERR_STEP;
      end else if (tx_success_i && tec_ff != 9'h000) begin
        nxt_tec = tec_ff - 9'h001;
      end
      if (rx_severe_i) begin
        nxt_rec = rec_ff + can_status_pkg::RX_SEVERE_STEP;
      end else if (rx_error_i) begin
        nxt_rec = rec_ff + can_status_pkg::RX_ERR_STEP;
      end else if (rx_success_i) begin
        if (rec_ff > {1'b0, can_status_pkg::PASSIVE_LIMIT}) begin
          nxt_rec = can_status_pkg::RX_PASSIVE_RELOAD;
        end else if (rec_ff != 9'h000) begin
          nxt_rec = rec_ff - 9'h001;
        end
      end
      // receive count saturates, it never forces bus-off
      if (nxt_rec > {1'b0, can_status_pkg::COUNT_SAT}) begin
        nxt_rec = {1'b0, can_status_pkg::COUNT_SAT};
      end
      // past 255 the transmitter leaves the bus
      if (nxt_tec > can_status_pkg::BUS_OFF_LIMIT) begin
        nxt_bus_off = 1'b1;
      end
    end
  end

  // counter state, bus-off comes up set
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      tec_ff <= can_status_pkg::RST_COUNT;
      rec_ff <= can_status_pkg::RST_COUNT;
      bus_off_ff <= 1'b1;
    end else if (ce_i) begin
      tec_ff <= nxt_tec;
      rec_ff <= nxt_rec;
      bus_off_ff <= nxt_bus_off;
    end
  end

  // an 8-bit field cannot show 256+, so it pins at 255
  assign tx_count_o = tec_ff[8] ? can_status_pkg::COUNT_SAT : tec_ff[7:0];
  assign rx_count_o = rec_ff[7:0];
  assign bus_off_o = bus_off_ff;

endmodule

/* File: user_addr_select.sv */
`timescale 1ns/100ps
module user_addr_select #(
  parameter int FIFO_N = 7,
  parameter int ADDR_W = 32
) (
  // clock and control
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // per fifo pointers and direction
  input wire logic [FIFO_N*ADDR_W-1:0] head_addr_i,
  input wire logic [FIFO_N*ADDR_W-1:0] tail_addr_i,
  input wire logic [FIFO_N-1:0] fifo_direction_transmit_i,
  // user address per fifo
  output logic [FIFO_N*ADDR_W-1:0] fifo_user_address_o
);

  genvar g;
  generate
    for (g = 0; g < FIFO_N; g++) begin : g_fifo
      // registered so a read never sees a half-switched pointer
      always_ff @(posedge mclk_i) begin
        if (reset_i) begin
          fifo_user_address_o[g*ADDR_W +: ADDR_W] <= ADDR_W'(0);
        end else if (ce_i) begin
          // transmit picks head, receive picks tail
          fifo_user_address_o[g*ADDR_W +: ADDR_W] <=
            fifo_direction_transmit_i[g] ? head_addr_i[g*ADDR_W +: ADDR_W]
                                         : tail_addr_i[g*ADDR_W +: ADDR_W];
        end
      end
    end
  endgenerate

endmodule

/* File: can_err_status.sv */
// Our own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
module can_err_status #(
  parameter int FIFO_N = can_status_pkg::FIFO_COUNT,
  parameter int ADDR_W = can_status_pkg::UA_W
) (
  // clock, reset, enable
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // axi4-lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // controller mode and fifo pointers
  input wire logic config_mode_i,
  input wire logic [FIFO_N-1:0] fifo_direction_transmit_i,
  input wire logic [FIFO_N*ADDR_W-1:0] fifo_head_addr_i,
  input wire logic [FIFO_N*ADDR_W-1:0] fifo_tail_addr_i,
  input wire logic [ADDR_W-1:0] event_fifo_tail_addr_i,
  input wire logic [ADDR_W-1:0] tx_queue_head_addr_i,
  // protocol engine error events
  input wire logic tx_error_i,
  input wire logic tx_success_i,
  input wire logic rx_error_i,
  input wire logic rx_severe_i,
  input wire logic rx_success_i,
  input wire logic recovered_i,
  // error state and interrupt
  output logic [5:0] error_state_flags_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  typedef enum {
    SEL_NONE, SEL_FIFO_HIGH, SEL_FIFO_LOW, SEL_EVT_HIGH, SEL_EVT_LOW,
    SEL_TXQ_HIGH, SEL_TXQ_LOW, SEL_FLAGS, SEL_COUNTS, SEL_INT_STATUS,
    SEL_INT_MASK
  } reg_sel_e;

  // fifo 1..7 of an address in the fifo window, else 0
  function automatic logic [3:0] fifo_index(input logic [11:0] addr);
    logic [11:0] rel;
    fifo_index = 4'h0;
    rel = addr - can_status_pkg::OFS_FIFO_UA_BASE;
    if (addr >= can_status_pkg::OFS_FIFO_UA_BASE &&
        rel < 12'(FIFO_N) * can_status_pkg::OFS_FIFO_STRIDE) begin
      fifo_index = 4'(rel[11:3]) + 4'h1;
    end
  endfunction

  // register select, shared by read and write
  function automatic reg_sel_e decode(input logic [11:0] addr);
    logic [11:0] word;
    word = {addr[11:2], 2'b00};
    decode = SEL_NONE;
    case (word)
      can_status_pkg::OFS_EVT_UA_HIGH: decode = SEL_EVT_HIGH;
      can_status_pkg::OFS_EVT_UA_LOW: decode = SEL_EVT_LOW;
      can_status_pkg::OFS_TXQ_UA_HIGH: decode = SEL_TXQ_HIGH;
      can_status_pkg::OFS_TXQ_UA_LOW: decode = SEL_TXQ_LOW;
      can_status_pkg::OFS_ERR_FLAGS: decode = SEL_FLAGS;
      can_status_pkg::OFS_ERR_COUNTS: decode = SEL_COUNTS;
      can_status_pkg::OFS_INT_STATUS: decode = SEL_INT_STATUS;
      can_status_pkg::OFS_INT_MASK: decode = SEL_INT_MASK;
      default: begin
        if (fifo_index(word) != 4'h0) begin
          decode = (word[2] == can_status_pkg::OFS_HALF_LOW[2]) ?
                   SEL_FIFO_LOW : SEL_FIFO_HIGH;
        end
      end
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // user address capture

  logic [FIFO_N*ADDR_W-1:0] fifo_user_address;
  logic [ADDR_W-1:0] event_fifo_user_address_ff;
  logic [ADDR_W-1:0] tx_queue_user_address_ff;

  user_addr_select #(
    .FIFO_N(FIFO_N),
    .ADDR_W(ADDR_W)
  ) u_fifo_ua (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .head_addr_i(fifo_head_addr_i),
    .tail_addr_i(fifo_tail_addr_i),
    .fifo_direction_transmit_i(fifo_direction_transmit_i),
    .fifo_user_address_o(fifo_user_address)
  );

  // pointers are not frozen in configuration mode; software must not
  // rely on them then, so no extra gating is spent here
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      event_fifo_user_address_ff <= can_status_pkg::RST_UA;
      tx_queue_user_address_ff <= can_status_pkg::RST_UA;
    end else if (ce_i) begin
      event_fifo_user_address_ff <= event_fifo_tail_addr_i;
      tx_queue_user_address_ff <= tx_queue_head_addr_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // error counts and derived flags

  logic [7:0] tx_error_count, rx_error_count;
  logic tx_bus_off;
  logic [5:0] flags_ff, nxt_flags;

  err_count_engine u_counts (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .config_mode_i(config_mode_i),
    .tx_error_i(tx_error_i),
    .tx_success_i(tx_success_i),
    .rx_error_i(rx_error_i),
    .rx_severe_i(rx_severe_i),
    .rx_success_i(rx_success_i),
    .recovered_i(recovered_i),
    .tx_count_o(tx_error_count),
    .rx_count_o(rx_error_count),
    .bus_off_o(tx_bus_off)
  );

  // flags follow the counts every cycle
  always_comb begin
    nxt_flags = '0;
    nxt_flags[can_status_pkg::BIT_BUS_OFF] = tx_bus_off;
    nxt_flags[can_status_pkg::BIT_TX_PASSIVE] =
      tx_error_count > can_status_pkg::PASSIVE_LIMIT;
    nxt_flags[can_status_pkg::BIT_RX_PASSIVE] =
      rx_error_count > can_status_pkg::PASSIVE_LIMIT;
    nxt_flags[can_status_pkg::BIT_TX_WARN] =
      tx_error_count > can_status_pkg::WARN_ABOVE &&
      tx_error_count < can_status_pkg::WARN_BELOW;
    nxt_flags[can_status_pkg::BIT_RX_WARN] =
      rx_error_count > can_status_pkg::WARN_ABOVE &&
      rx_error_count < can_status_pkg::WARN_BELOW;
    nxt_flags[can_status_pkg::BIT_ANY_WARN] =
      nxt_flags[can_status_pkg::BIT_TX_WARN] |
      nxt_flags[can_status_pkg::BIT_RX_WARN];
  end

  // flags trail the counts by one cycle
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      flags_ff <= can_status_pkg::RST_FLAGS;
    end else if (ce_i) begin
      flags_ff <= nxt_flags;
    end
  end

  assign error_state_flags_o = flags_ff;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status and mask

  logic [4:0] int_status_ff, int_mask_ff, int_event;
  logic wr_fire;
  logic [31:0] wr_data_ff;
  reg_sel_e wr_sel;
  logic [11:0] wr_addr_ff;
  logic [3:0] s_axi_wstrb_ff;

  // rises of bus-off, both passive flags and any-warning are the events, and the bus-off fall is the recovered event
  always_comb begin
    int_event = '0;
    int_event[can_status_pkg::INT_BUS_OFF] =
      nxt_flags[can_status_pkg::BIT_BUS_OFF] &
      ~flags_ff[can_status_pkg::BIT_BUS_OFF];
    int_event[can_status_pkg::INT_TX_PASSIVE] =
      nxt_flags[can_status_pkg::BIT_TX_PASSIVE] &
      ~flags_ff[can_status_pkg::BIT_TX_PASSIVE];
    int_event[can_status_pkg::INT_RX_PASSIVE] =
      nxt_flags[can_status_pkg::BIT_RX_PASSIVE] &
      ~flags_ff[can_status_pkg::BIT_RX_PASSIVE];
    int_event[can_status_pkg::INT_WARN] =
      nxt_flags[can_status_pkg::BIT_ANY_WARN] &
      ~flags_ff[can_status_pkg::BIT_ANY_WARN];
    int_event[can_status_pkg::INT_RECOVERED] =
      ~nxt_flags[can_status_pkg::BIT_BUS_OFF] &
      flags_ff[can_status_pkg::BIT_BUS_OFF];
  end

  assign wr_sel = decode(wr_addr_ff);

  // write-one-to-clear; a new event in the same cycle wins
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      int_status_ff <= can_status_pkg::RST_INT;
    end else if (ce_i) begin
      if (wr_fire && wr_sel == SEL_INT_STATUS && s_axi_wstrb_ff[0]) begin
        int_status_ff <= (int_status_ff & ~wr_data_ff[4:0]) | int_event;
      end else begin
        int_status_ff <= int_status_ff | int_event;
      end
    end
  end

  // mask: one enables the matching status bit onto the line
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      int_mask_ff <= can_status_pkg::RST_INT;
    end else if (ce_i) begin
      if (wr_fire && wr_sel == SEL_INT_MASK && s_axi_wstrb_ff[0]) begin
        int_mask_ff <= wr_data_ff[4:0];
      end
    end
  end

  assign irq_o = |(int_status_ff & int_mask_ff);

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel

  logic aw_held_ff, w_held_ff, bvalid_ff;
  logic [1:0] bresp_ff;

  // each half held until the response goes
  assign s_axi_awready = ~aw_held_ff & ~bvalid_ff;
  assign s_axi_wready = ~w_held_ff & ~bvalid_ff;
  assign wr_fire = aw_held_ff & w_held_ff & ~bvalid_ff;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      aw_held_ff <= 1'b0;
      wr_addr_ff <= '0;
    end else if (ce_i) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        wr_addr_ff <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      w_held_ff <= 1'b0;
      wr_data_ff <= '0;
      s_axi_wstrb_ff <= '0;
    end else if (ce_i) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        wr_data_ff <= s_axi_wdata;
        s_axi_wstrb_ff <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_ff <= 1'b0;
      end
    end
  end

  // status-only registers accept writes silently; holes get slverr
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= can_status_pkg::RESP_OKAY;
    end else if (ce_i) begin
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= (wr_sel == SEL_NONE) ? can_status_pkg::RESP_SLVERR
                                         : can_status_pkg::RESP_OKAY;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel

  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff, rd_word;
  reg_sel_e rd_sel;
  logic [3:0] rd_fifo;
  logic [ADDR_W-1:0] rd_fifo_ua;

  assign rd_sel = decode(s_axi_araddr);
  assign rd_fifo = fifo_index({s_axi_araddr[11:2], 2'b00});

  // pick the user address of the addressed fifo
  always_comb begin
    rd_fifo_ua = '0;
    for (int i = 0; i < FIFO_N; i++) begin
      if (rd_fifo == 4'(i + 1)) begin
        rd_fifo_ua = fifo_user_address[i*ADDR_W +: ADDR_W];
      end
    end
  end

  // values are only trusted outside configuration mode
  always_comb begin
    rd_word = '0;
    case (rd_sel)
      SEL_FIFO_HIGH: rd_word[15:0] = rd_fifo_ua[31:16];
      SEL_FIFO_LOW: rd_word[15:0] = rd_fifo_ua[15:0];
      SEL_EVT_HIGH: rd_word[15:0] = event_fifo_user_address_ff[31:16];
      SEL_EVT_LOW: rd_word[15:0] = event_fifo_user_address_ff[15:0];
      SEL_TXQ_HIGH: rd_word[15:0] = tx_queue_user_address_ff[31:16];
      SEL_TXQ_LOW: rd_word[15:0] = tx_queue_user_address_ff[15:0];
      SEL_FLAGS: rd_word[5:0] = flags_ff;
      SEL_COUNTS: begin
        rd_word[can_status_pkg::TX_CNT_LSB +: 8] = tx_error_count;
        rd_word[can_status_pkg::RX_CNT_LSB +: 8] = rx_error_count;
      end
      SEL_INT_STATUS: rd_word[4:0] = int_status_ff;
      SEL_INT_MASK: rd_word[4:0] = int_mask_ff;
      default: rd_word = '0;
    endcase
  end

  // one read in flight
  assign s_axi_arready = ~rvalid_ff;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= can_status_pkg::RESP_OKAY;
    end else if (ce_i) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_word;
        rresp_ff <= (rd_sel == SEL_NONE) ? can_status_pkg::RESP_SLVERR
                                         : can_status_pkg::RESP_OKAY;
      end else if (s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

endmodule

/* File: can_engine_model.sv */
`timescale 1ns/100ps
module can_engine_model (
  // clock
  input wire logic mclk_i,
  // error events: tx err, tx ok, rx err, rx severe, rx ok, recovered
  output logic [5:0] event_o,
  // message ram pointers
  output logic [223:0] head_o,
  output logic [223:0] tail_o,
  output logic [31:0] evt_tail_o,
  output logic [31:0] txq_head_o
);
  //////////////////////////////////////////////////////////////////////
  // halves differ so a swapped word shows
  always_comb begin
    for (int g = 0; g < 7; g++) begin
      head_o[g*32+:32] = 32'h1a00_0400 + g * 32'h0001_0010;
      tail_o[g*32+:32] = 32'h2b00_0800 + g * 32'h0001_0010;
    end
  end
  assign evt_tail_o = 32'h3c00_0c40;
  assign txq_head_o = 32'h4d00_1080;
  initial event_o = 6'h00;
  // pulses with a quiet cycle between
  task automatic pulse(input int k, input int n);
    repeat (n) begin
      @(posedge mclk_i);
      event_o <= 6'h01 << k;
      @(posedge mclk_i);
      event_o <= 6'h00;
    end
  endtask
endmodule

/* File: can_err_status_sva.sv */
`timescale 1ns/100ps
module can_err_status_sva (
  // clock and control
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic config_mode_i,
  input wire logic tx_error_i,
  input wire logic tx_success_i,
  // bus handshakes
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // flags
  input wire logic [5:0] error_state_flags_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);
  sequence read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // flags lag counts a cycle
  sequence tx_hit2;
    $past(tx_error_i, 2);
  endsequence
  //////////////////////////////////////////////////////////////////////
  AST_ANY_WARN: assert property (
    error_state_flags_o[0] == |error_state_flags_o[2:1]
  ) else $error("any warning wrong");
  AST_TX_WARN_EXCL: assert property (
    error_state_flags_o[2] |-> !error_state_flags_o[4]
  ) else $error("tx warning with tx passive");
  AST_RX_WARN_EXCL: assert property (
    error_state_flags_o[1] |-> !error_state_flags_o[3]
  ) else $error("rx warning with rx passive");
  AST_CFG_BUS_OFF: assert property (
    config_mode_i && ce_i |-> ##2 error_state_flags_o[5]
  ) else $error("bus-off not held in configuration");
  AST_RESET_FLAGS: assert property (
    $fell(reset_i) |-> error_state_flags_o == 6'h20
  ) else $error("flags wrong after reset");
  AST_TX_WARN_CAUSE: assert property (
    $rose(error_state_flags_o[2]) |-> tx_hit2 or $past(tx_success_i, 2)
  ) else $error("tx warning without cause");
  AST_BUS_OFF_CAUSE: assert property (
    $rose(error_state_flags_o[5]) |-> tx_hit2 or $past(config_mode_i, 2)
  ) else $error("bus-off rose without cause");
  AST_READ_ANSWER: assert property (
    read_taken |=> s_axi_rvalid
  ) else $error("read not answered");
  AST_READ_HOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
  ) else $error("read data not held");
  AST_WRITE_DONE: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid
  ) else $error("write response not dropped");
endmodule
bind can_err_status can_err_status_sva chk (
  .mclk_i(mclk_i), .reset_i(reset_i), .ce_i(ce_i),
  .config_mode_i(config_mode_i), .tx_error_i(tx_error_i),
  .tx_success_i(tx_success_i),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .error_state_flags_o(error_state_flags_o)
);

/* File: can_err_status_tb.sv */
`timescale 1ns/100ps
module can_err_status_tb;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic config_mode_i = 1'b1;
  logic [6:0] dir = 7'h55;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  wire logic awready, wready, bvalid, arready, rvalid, irq;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata, et, tq;
  wire logic [5:0] flags, ev;
  wire logic [223:0] hd, tl;
  logic [1:0] resp;
  logic [31:0] v, e32;
  int err_count = 0;
  int samples_checked = 0;
  // kind, count, expected flags and counts
  int kk[11] = '{0, 1, 0, 0, 2, 2, 2, 4, 3, 0, 0};
  int nn[11] = '{12, 1, 4, 1, 96, 31, 1, 1, 1, 15, 1};
  logic [5:0] ef[11] = '{6'h05, 6'h00, 6'h05, 6'h10, 6'h13, 6'h13,
    6'h18, 6'h13, 6'h18, 6'h18, 6'h38};
  logic [15:0] ec[11] = '{16'h6000, 16'h5f00, 16'h7f00, 16'h8700,
    16'h8760, 16'h877f, 16'h8780, 16'h8778, 16'h8780, 16'hff80, 16'hff80};

  always #2 mclk_i = ~mclk_i;

  can_engine_model eng (.mclk_i(mclk_i), .event_o(ev), .head_o(hd),
    .tail_o(tl), .evt_tail_o(et), .txq_head_o(tq));
  can_err_status dut (.mclk_i(mclk_i), .reset_i(reset_i), .ce_i(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .config_mode_i(config_mode_i),
    .fifo_direction_transmit_i(dir), .fifo_head_addr_i(hd),
    .fifo_tail_addr_i(tl), .event_fifo_tail_addr_i(et),
    .tx_queue_head_addr_i(tq), .tx_error_i(ev[0]), .tx_success_i(ev[1]),
    .rx_error_i(ev[2]), .rx_severe_i(ev[3]), .rx_success_i(ev[4]),
    .recovered_i(ev[5]), .error_state_flags_o(flags), .irq_o(irq));

  //////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // handshake seen before the edge, dropped just after it
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    @(posedge mclk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge mclk_i);
      ha = awvalid & awready;
      hw = wvalid & wready;
      hb = bvalid & bready;
      resp = bresp;
      @(posedge mclk_i);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) bready <= 1'b0;
    end while (!hb);
  endtask
  task automatic rd(input logic [11:0] a);
    logic ha, hr;
    @(posedge mclk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge mclk_i);
      ha = arvalid & arready;
      hr = rvalid & rready;
      v = rdata;
      resp = rresp;
      @(posedge mclk_i);
      if (ha) arvalid <= 1'b0;
      if (hr) rready <= 1'b0;
    end while (!hr);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    check(v, e);
    check(32'(resp), 32'(can_status_pkg::RESP_OKAY));
  endtask
  // flags lag counts a cycle
  task automatic flg(input logic [5:0] e, input logic q);
    repeat (3) @(posedge mclk_i);
    @(negedge mclk_i);
    check(32'(flags), 32'(e));
    check(32'(irq), 32'(q));
  endtask
  task automatic give_verdict;
    $display("checks %0d, errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    repeat (20000) @(posedge mclk_i);
    err_count++;
    give_verdict;
  end
  initial begin
    repeat (8) @(posedge mclk_i);
    reset_i <= 1'b0;
    rdc(can_status_pkg::OFS_ERR_FLAGS, 32'h20);
    rdc(can_status_pkg::OFS_ERR_COUNTS, 32'h0);
    @(posedge mclk_i);
    config_mode_i <= 1'b0;
    // pointers lag a cycle
    for (int p = 0; p < 2; p++) begin
      dir <= p ? 7'h2a : 7'h55;
      repeat (2) @(posedge mclk_i);
      for (int x = 0; x < 7; x++) begin
        e32 = (dir[x] ? 32'h1a00_0400 : 32'h2b00_0800) + x * 32'h0001_0010;
        rdc(can_status_pkg::OFS_FIFO_UA_BASE + 12'(8 * x),
          {16'h0, e32[31:16]});
        rdc(can_status_pkg::OFS_FIFO_UA_BASE + 12'(8 * x + 4),
          {16'h0, e32[15:0]});
      end
    end
    rdc(can_status_pkg::OFS_EVT_UA_HIGH, 32'h3c00);
    rdc(can_status_pkg::OFS_EVT_UA_LOW, 32'h0c40);
    rdc(can_status_pkg::OFS_TXQ_UA_HIGH, 32'h4d00);
    rdc(can_status_pkg::OFS_TXQ_UA_LOW, 32'h1080);
    // hole read, ignored write
    rd(12'h100);
    check(v, 32'h0);
    check(32'(resp), 32'(can_status_pkg::RESP_SLVERR));
    wr(can_status_pkg::OFS_ERR_COUNTS, 32'hffff);
    rdc(can_status_pkg::OFS_ERR_COUNTS, 32'h0);
    // leave bus-off, clear its sticky bit
    eng.pulse(5, 1);
    flg(6'h00, 1'b0);
    rdc(can_status_pkg::OFS_INT_STATUS, 32'h10);
    wr(can_status_pkg::OFS_INT_STATUS, 32'h10);
    rdc(can_status_pkg::OFS_INT_STATUS, 32'h0);
    // cross every threshold
    for (int i = 0; i < 11; i++) begin
      eng.pulse(kk[i], nn[i]);
      flg(ef[i], 1'b0);
      rdc(can_status_pkg::OFS_ERR_COUNTS, {16'h0, ec[i]});
    end
    rdc(can_status_pkg::OFS_ERR_FLAGS, 32'h38);
    rdc(can_status_pkg::OFS_INT_STATUS, 32'h0f);
    wr(can_status_pkg::OFS_INT_MASK, 32'h01);
    flg(6'h38, 1'b1);
    wr(can_status_pkg::OFS_INT_STATUS, 32'h01);
    flg(6'h38, 1'b0);
    eng.pulse(5, 1);
    flg(6'h00, 1'b0);
    rdc(can_status_pkg::OFS_INT_STATUS, 32'h1e);
    wr(can_status_pkg::OFS_INT_MASK, 32'h10);
    flg(6'h00, 1'b1);
    @(posedge mclk_i);
    config_mode_i <= 1'b1;
    flg(6'h20, 1'b1);
    rdc(can_status_pkg::OFS_ERR_COUNTS, 32'h0);
    give_verdict;
  end
endmodule
